// ==== logic/hlcs_consts.svh ====
// constants for the host lane and cascade select block
// assumes inclusion by package, interface and both end modules
`ifndef HLCS_CONSTS_SVH
`define HLCS_CONSTS_SVH
`define HLCS_AW 13
`define HLCS_DW 16
`define HLCS_BOOT_AW 10
`define HLCS_BOOT_WORDS 512
`define HLCS_BOOT_BASE 13'h0000
`define HLCS_REG_TOP 13'h1800
`define HLCS_HOLD 4'hF
`define HLCS_REG_BASE 13'h1000
`define HLCS_REG_DEVSEL 13'h1000
`define HLCS_REG_CONFIG 13'h1002
`define HLCS_REG_DATA 13'h1004
`define HLCS_CFG_MAXID_LSB 0
`define HLCS_ALIAS_1K 3'h1
`define HLCS_ALIAS_6K 3'h6
`define HLCS_ALIAS_7K 3'h7
`define HLCS_CMD_WR 2'h1
`define HLCS_CMD_RD 2'h2
`endif

// ==== logic/hlcs_pkg.sv ====
// lane type for the device end and state type for the host end of the host lane and cascade select link
// assumes hlcs_consts.svh on the include path
`default_nettype none
`include "hlcs_consts.svh"
package hlcs_pkg;
  typedef enum logic [1:0] {
    HLCS_LANE_WORD = 2'h0,
    HLCS_LANE_ODD = 2'h1,
    HLCS_LANE_EVEN = 2'h2,
    HLCS_LANE_NOP = 2'h3
  } hlcs_lane_t;
  typedef enum logic [1:0] {
    HLCS_ST_IDLE = 2'h0,
    HLCS_ST_DRIVE = 2'h1,
    HLCS_ST_DONE = 2'h2
  } hlcs_state_t;
endpackage
`default_nettype wire

// ==== logic/hlcs_if.sv ====
// bus between a host adapter and one cascaded device
// data bus is shared; wire level is resolved by the testbench from enables
`timescale 1ns/10ps
`default_nettype none
`include "hlcs_consts.svh"
interface hlcs_if;
  logic [`HLCS_AW-1:0] addr;
  logic byte_high_enable_n;
  logic width16;
  logic mux_mode;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [`HLCS_DW-1:0] host_dout;
  logic host_doe_n;
  logic [`HLCS_DW-1:0] dev_dout;
  logic [1:0] dev_doe_n;
  logic [`HLCS_DW-1:0] din;
  modport host (
    output addr, byte_high_enable_n, width16, mux_mode, cs_n, rd_n, wr_n,
    output host_dout, host_doe_n,
    input din
  );
  modport dev (
    input addr, byte_high_enable_n, width16, mux_mode, cs_n, rd_n, wr_n,
    input din,
    output dev_dout, dev_doe_n
  );
endinterface
`default_nettype wire

// ==== logic/hlcs_dev.sv ====
// device end: lane decode, cascade identity select, boot block window
// assumes one clock mclk; bus pins are asynchronous and synchronised here
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "hlcs_consts.svh"
// Behaviour
// - host holds width select for 16-bit
// - both low gives full word transfer
// - odd byte uses upper data lanes
// - even byte uses lower data lanes
// - both high is a no-operation
// - word-only host ties both low
// - boot block answers 8 or 16-bit
// - 32-bit host wires address, ties low
// - up to four devices cascade, no decoder
// - two-bit strap gives cascade position
// - registers answer only on identity match
// - multiplexed bus cascades two by low strap
// - boot window grows 1KB per device
// - highest device number splits boot ranges
// - after reset device 0 aliased
// - width select low 8-bit, high 16-bit
// - multiplexed mode forces high strap zero
module hlcs_dev (
  input wire logic mclk,
  input wire logic rst,
  hlcs_if.dev bus,
  input wire logic [1:0] chip_identity_strap,
  input wire logic boot_wr,
  input wire logic [`HLCS_BOOT_AW-1:0] boot_wr_addr,
  input wire logic [`HLCS_DW-1:0] boot_wr_data,
  output logic [1:0] device_select_q,
  output logic [1:0] highest_device_number_q,
  output logic [1:0] own_identity,
  output logic selected,
  output logic [`HLCS_DW-1:0] scratch_q
);
  logic [`HLCS_AW-1:0] addr_s1_q, addr_s2_q;
  logic [`HLCS_DW-1:0] din_s1_q, din_s2_q;
  logic [5:0] ctl_s1_q, ctl_s2_q;
  logic rd_prev_q, wr_prev_q;
  logic [`HLCS_DW-1:0] dout_q;
  logic [1:0] oe_n_q;
  logic [1:0] strap_s1_q;
  logic [1:0] strap_q;
  logic [`HLCS_DW-1:0] boot_mem [0:`HLCS_BOOT_WORDS-1];

  always_ff @(posedge mclk)
  begin
    addr_s1_q <= bus.addr;
    addr_s2_q <= addr_s1_q;
    din_s1_q <= bus.din;
    din_s2_q <= din_s1_q;
    ctl_s1_q <= {bus.mux_mode, bus.width16, bus.byte_high_enable_n,
                 bus.cs_n, bus.rd_n, bus.wr_n};
    ctl_s2_q <= ctl_s1_q;
  end

  wire mux_s = ctl_s2_q[5];
  wire width16_s = ctl_s2_q[4];
  wire bhe_n_s = ctl_s2_q[3];
  wire cs_s = ~ctl_s2_q[2];
  wire rd_s = ~ctl_s2_q[1];
  wire wr_s = ~ctl_s2_q[0];

  // strap is a board pin, so it passes two stages like the bus pins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      strap_s1_q <= 2'h0;
      strap_q <= 2'h0;
    end
    else
    begin
      strap_s1_q <= chip_identity_strap;
      strap_q <= strap_s1_q;
    end
  end
  assign own_identity = {strap_q[1] & ~mux_s, strap_q[0]};

  function automatic hlcs_pkg::hlcs_lane_t lane_of(input logic w16, input logic bhe_n,
                                                   input logic a0);
    if (!w16)
      lane_of = hlcs_pkg::HLCS_LANE_EVEN;
    else
      lane_of = hlcs_pkg::hlcs_lane_t'({bhe_n, a0});
  endfunction

  wire hlcs_pkg::hlcs_lane_t lane = lane_of(width16_s, bhe_n_s, addr_s2_q[0]);
  // byte lanes of one register share a word, so decode drops the low bit
  wire [`HLCS_AW-1:0] reg_word = {addr_s2_q[`HLCS_AW-1:1], 1'b0};
  wire in_reg = addr_s2_q >= `HLCS_REG_BASE && addr_s2_q < `HLCS_REG_TOP;
  // registers sit below the 6K alias, so slots 6 and 7 stay boot space
  wire in_boot = !in_reg;
  wire [2:0] kb_slot = addr_s2_q[`HLCS_AW-1:`HLCS_BOOT_AW];
  // before software sets highest number only device 0 answers, aliased
  wire alias_hit = kb_slot == 3'h0 || kb_slot == `HLCS_ALIAS_1K
    || kb_slot == `HLCS_ALIAS_6K || kb_slot == `HLCS_ALIAS_7K;
  wire boot_mine = (highest_device_number_q == 2'h0)
    ? (own_identity == 2'h0 && alias_hit)
    : (kb_slot == {1'b0, own_identity} && own_identity <= highest_device_number_q);
  assign selected = device_select_q == own_identity;
  wire reg_hit = in_reg && selected;
  wire boot_hit = in_boot && boot_mine;
  wire rd_start = cs_s && rd_s && !rd_prev_q;
  wire wr_start = cs_s && wr_s && !wr_prev_q;
  wire [`HLCS_BOOT_AW-2:0] boot_word = addr_s2_q[`HLCS_BOOT_AW-1:1];
  wire [`HLCS_DW-1:0] boot_data = boot_mem[boot_word];
  // 8-bit host reads the odd byte on the low lane
  wire [`HLCS_DW-1:0] boot_rd = (!width16_s && addr_s2_q[0])
    ? {8'h00, boot_data[15:8]} : boot_data;

  // every value is an argument so the continuous assignment sees each change
  function automatic logic [`HLCS_DW-1:0] reg_read(input logic [`HLCS_AW-1:0] word_addr,
                                                   input logic [1:0] dev_sel,
                                                   input logic [1:0] highest_device_number,
                                                   input logic [`HLCS_DW-1:0] scratch);
    if (word_addr == `HLCS_REG_DEVSEL)
      reg_read = {14'h0000, dev_sel};
    else if (word_addr == `HLCS_REG_CONFIG)
      reg_read = {14'h0000, highest_device_number};
    else if (word_addr == `HLCS_REG_DATA)
      reg_read = scratch;
    else
      reg_read = 16'h0000;
  endfunction

  // low bit releases the low lane, high bit the high lane
  function automatic logic [1:0] lane_oe_of(input hlcs_pkg::hlcs_lane_t ln);
    case (ln)
      hlcs_pkg::HLCS_LANE_WORD: lane_oe_of = 2'h0;
      hlcs_pkg::HLCS_LANE_ODD: lane_oe_of = 2'h1;
      hlcs_pkg::HLCS_LANE_EVEN: lane_oe_of = 2'h2;
      default: lane_oe_of = 2'h3;
    endcase
  endfunction

  wire [`HLCS_DW-1:0] reg_rd = reg_read(reg_word, device_select_q, highest_device_number_q,
                                        scratch_q);
  wire [1:0] lane_oe_n = lane_oe_of(lane);

  // preload port runs on mclk, so it needs no synchroniser
  wire [`HLCS_BOOT_AW-2:0] boot_word_w = boot_wr_addr[`HLCS_BOOT_AW-1:1];
  always_ff @(posedge mclk)
  begin
    if (boot_wr)
      boot_mem[boot_word_w] <= boot_wr_data;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end
    else
    begin
      rd_prev_q <= cs_s && rd_s;
      wr_prev_q <= cs_s && wr_s;
    end
  end

  // device-select write is seen by all chips so any one can be picked
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      device_select_q <= 2'h0;
      highest_device_number_q <= 2'h0;
      scratch_q <= 16'h0000;
    end
    else if (wr_start && lane != hlcs_pkg::HLCS_LANE_NOP)
    begin
      if (reg_word == `HLCS_REG_DEVSEL)
        device_select_q <= din_s2_q[1:0];
      else if (reg_word == `HLCS_REG_CONFIG && selected)
        highest_device_number_q <= din_s2_q[`HLCS_CFG_MAXID_LSB+1:`HLCS_CFG_MAXID_LSB];
      else if (reg_word == `HLCS_REG_DATA && selected)
      begin
        if (!lane_oe_n[0])
          scratch_q[7:0] <= din_s2_q[7:0];
        if (!lane_oe_n[1])
          scratch_q[15:8] <= din_s2_q[15:8];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dout_q <= 16'h0000;
      oe_n_q <= 2'h3;
    end
    else if (rd_start && (reg_hit || boot_hit))
    begin
      dout_q <= reg_hit ? reg_rd : boot_rd;
      oe_n_q <= lane_oe_n;
    end
    else if (!(cs_s && rd_s))
      oe_n_q <= 2'h3;
  end

  assign bus.dev_dout = dout_q;
  assign bus.dev_doe_n = oe_n_q;
endmodule
`default_nettype wire

// ==== logic/hlcs_host.sv ====
// host end: turns one-cycle register commands into strobed bus cycles
// assumes device drives din within the hold window of HLCS_HOLD cycles
`timescale 1ns/10ps
`default_nettype none
`include "hlcs_consts.svh"
module hlcs_host (
  input wire logic mclk,
  input wire logic rst,
  hlcs_if.host bus,
  input wire logic cfg_width16,
  input wire logic cfg_mux,
  input wire logic cfg_word_only,
  input wire logic [1:0] cmd,
  input wire logic [`HLCS_AW-1:0] cmd_addr,
  input wire logic cmd_bhe_n,
  input wire logic [`HLCS_DW-1:0] cmd_wdata,
  output logic busy,
  output logic rd_valid_q,
  output logic [`HLCS_DW-1:0] rd_data_q
);
  hlcs_pkg::hlcs_state_t state_q, state_d;
  logic [3:0] cnt_q;
  logic is_rd_q;
  logic [`HLCS_AW-1:0] addr_q;
  logic bhe_n_q;
  logic [`HLCS_DW-1:0] wdata_q;
  logic [`HLCS_DW-1:0] din_s1_q, din_s2_q;

  // long hold so the device sees strobes through its two-stage synchroniser
  wire cnt_done = cnt_q == `HLCS_HOLD;
  wire take = state_q == hlcs_pkg::HLCS_ST_IDLE && cmd != 2'h0;
  assign busy = state_q != hlcs_pkg::HLCS_ST_IDLE;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      hlcs_pkg::HLCS_ST_IDLE: if (take) state_d = hlcs_pkg::HLCS_ST_DRIVE;
      hlcs_pkg::HLCS_ST_DRIVE: if (cnt_done) state_d = hlcs_pkg::HLCS_ST_DONE;
      hlcs_pkg::HLCS_ST_DONE: if (cnt_done) state_d = hlcs_pkg::HLCS_ST_IDLE;
      default: state_d = hlcs_pkg::HLCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    din_s1_q <= bus.din;
    din_s2_q <= din_s1_q;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= hlcs_pkg::HLCS_ST_IDLE;
      cnt_q <= 4'h0;
      is_rd_q <= 1'b0;
      addr_q <= 13'h0000;
      bhe_n_q <= 1'b1;
      wdata_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= (state_q == state_d) ? cnt_q + 4'h1 : 4'h0;
      rd_valid_q <= 1'b0;
      if (take)
      begin
        is_rd_q <= cmd == `HLCS_CMD_RD;
        // word-only host forces low address bit and high enable low
        addr_q <= cfg_word_only ? {cmd_addr[12:1], 1'b0} : cmd_addr;
        bhe_n_q <= cfg_word_only ? 1'b0 : cmd_bhe_n;
        wdata_q <= cmd_wdata;
      end
      if (state_q == hlcs_pkg::HLCS_ST_DRIVE && cnt_done && is_rd_q)
      begin
        rd_valid_q <= 1'b1;
        rd_data_q <= din_s2_q;
      end
    end
  end

  wire active = state_q == hlcs_pkg::HLCS_ST_DRIVE;
  assign bus.width16 = cfg_width16;
  assign bus.mux_mode = cfg_mux;
  assign bus.addr = addr_q;
  assign bus.byte_high_enable_n = bhe_n_q;
  assign bus.cs_n = ~active;
  assign bus.rd_n = ~(active && is_rd_q);
  assign bus.wr_n = ~(active && !is_rd_q);
  assign bus.host_dout = wdata_q;
  assign bus.host_doe_n = ~(busy && !is_rd_q);
endmodule
`default_nettype wire

// ==== testbench/hlcs_link_asserts.sv ====
// assertions on the link between the host and device ends
// assumes plain copies of the interface signals and one clock
`timescale 1ns/10ps
`default_nettype none
module hlcs_link_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [12:0] addr,
  input wire logic byte_high_enable_n,
  input wire logic width16,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic host_doe_n,
  input wire logic [1:0] dev_doe_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // lane inputs held four cycles, so the pin synchronisers have caught up
  wire hi_w = width16 & ~byte_high_enable_n;
  wire lo_w = width16 & ~addr[0];
  property p_word; (hi_w & lo_w) [*4] |-> dev_doe_n[0] == dev_doe_n[1]; endproperty
  a_word: assert property (p_word) else $error("word cycle split lanes");
  property p_odd; (hi_w & addr[0]) [*4] |-> dev_doe_n[0]; endproperty
  a_odd: assert property (p_odd) else $error("odd byte on low lane");
  property p_even; (lo_w & byte_high_enable_n) [*4] |-> dev_doe_n[1]; endproperty
  a_even: assert property (p_even) else $error("even byte on high lane");
  property p_nop; (hi_w | lo_w | !width16) or (dev_doe_n == 2'h3); endproperty
  a_nop: assert property (p_nop) else $error("no-op cycle drove data");
  property p_byte8; (!width16) [*4] |-> dev_doe_n[1]; endproperty
  a_byte8: assert property (p_byte8) else $error("8-bit mode on high lane");
  property p_start; $fell(dev_doe_n[0]) |-> !rd_n && !cs_n; endproperty
  a_start: assert property (p_start) else $error("drive outside read");
  property p_release; $rose(rd_n) |-> ##[1:4] dev_doe_n == 2'h3; endproperty
  a_release: assert property (p_release) else $error("drive after read");
  property p_clash; !host_doe_n |-> dev_doe_n == 2'h3; endproperty
  a_clash: assert property (p_clash) else $error("both ends drive data");
endmodule
`default_nettype wire

// ==== testbench/host_lane_and_cascade_select_tb.sv ====
// bench joining host and device ends over one link
// assumes design files and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module host_lane_and_cascade_select_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic w16 = 1'b1;
  logic mux = 1'b0;
  logic wo = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [12:0] ca = 13'h0000;
  logic bhe_n = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [1:0] strap = 2'h0;
  logic bw = 1'b0;
  logic [9:0] ba = 10'h000;
  logic [15:0] bd = 16'h0000;
  logic [15:0] flt = 16'h5A5A;
  logic busy;
  logic [15:0] rdq;
  logic [15:0] scr;
  logic [1:0] oid;
  logic rdv;
  logic sel;
  logic [1:0] dsel;
  logic [1:0] hdn;
  int miscompares = 0;
  int comparisons = 0;
  hlcs_if i_hlcs_if ();
  wire [1:0] doe_n = i_hlcs_if.dev_doe_n;
  wire [15:0] hd = i_hlcs_if.host_doe_n ? flt : i_hlcs_if.host_dout;
  // released high lane has a pull-up in 8-bit mode while the host is not driving; otherwise it carries host data, or the flt pattern that toggles each cycle
  assign i_hlcs_if.din[15:8] = !doe_n[1] ? i_hlcs_if.dev_dout[15:8] :
    (!i_hlcs_if.width16 && i_hlcs_if.host_doe_n) ? 8'hFF : hd[15:8];
  assign i_hlcs_if.din[7:0] = !doe_n[0] ? i_hlcs_if.dev_dout[7:0] : hd[7:0];
  hlcs_host i_hlcs_host (.mclk(mclk), .rst(rst), .bus(i_hlcs_if.host), .cfg_width16(w16),
    .cfg_mux(mux), .cfg_word_only(wo), .cmd(cmd), .cmd_addr(ca), .cmd_bhe_n(bhe_n),
    .cmd_wdata(wd), .busy(busy), .rd_valid_q(rdv), .rd_data_q(rdq));
  hlcs_dev i_hlcs_dev (.mclk(mclk), .rst(rst), .bus(i_hlcs_if.dev), .chip_identity_strap(strap),
    .boot_wr(bw), .boot_wr_addr(ba), .boot_wr_data(bd), .device_select_q(dsel),
    .highest_device_number_q(hdn), .own_identity(oid), .selected(sel), .scratch_q(scr));
  hlcs_link_asserts i_hlcs_link_asserts (.mclk(mclk), .rst(rst), .addr(i_hlcs_if.addr),
    .byte_high_enable_n(i_hlcs_if.byte_high_enable_n), .width16(i_hlcs_if.width16),
    .cs_n(i_hlcs_if.cs_n), .rd_n(i_hlcs_if.rd_n), .host_doe_n(i_hlcs_if.host_doe_n),
    .dev_doe_n(doe_n));
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) flt <= ~flt;
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task xfer(input logic [1:0] c, input logic [12:0] a, input logic b, input logic [15:0] d);
    int n;
    int v;
    n = 0;
    v = 0;
    @(posedge mclk);
    cmd <= c;
    ca <= a;
    bhe_n <= b;
    wd <= d;
    @(posedge mclk);
    cmd <= 2'h0;
    do
    begin
      @(posedge mclk);
      n++;
      if (rdv === 1'b1)
        v++;
    end
    while (busy !== 1'b0 && n < 100);
    chk("busy", 16'h0000, {15'h0000, busy});
    chk("rd valid", (c == 2'h2) ? 16'h0001 : 16'h0000, v[15:0]);
  endtask
  task load(input logic [9:0] a, input logic [15:0] d);
    @(posedge mclk);
    bw <= 1'b1;
    ba <= a;
    bd <= d;
    @(posedge mclk);
    bw <= 1'b0;
  endtask
  task t_lanes;
    xfer(2'h1, 13'h1000, 1'b0, 16'h0000);
    xfer(2'h1, 13'h1004, 1'b0, 16'hBEEF);
    xfer(2'h2, 13'h1004, 1'b0, 16'h0000);
    chk("word rd", 16'hBEEF, rdq);
    xfer(2'h2, 13'h1005, 1'b0, 16'h0000);
    chk("odd rd", 16'h00BE, {8'h00, rdq[15:8]});
    xfer(2'h2, 13'h1004, 1'b1, 16'h0000);
    chk("even rd", 16'h00EF, {8'h00, rdq[7:0]});
    xfer(2'h1, 13'h1005, 1'b0, 16'h7700);
    chk("odd wr", 16'h77EF, scr);
    xfer(2'h1, 13'h1004, 1'b1, 16'h0022);
    chk("even wr", 16'h7722, scr);
    xfer(2'h1, 13'h1005, 1'b1, 16'h1111);
    chk("nop wr", 16'h7722, scr);
    xfer(2'h2, 13'h1005, 1'b1, 16'h0000);
    chk("nop rd", 16'h0000, {15'h0000, rdq === 16'h7722});
  endtask
  task t_ident;
    for (int i = 0; i < 4; i++)
    begin
      strap <= i[1:0];
      xfer(2'h1, 13'h1000, 1'b0, {14'h0000, i[1:0]});
      chk("own id", {14'h0000, i[1:0]}, {14'h0000, oid});
      chk("dev sel", {14'h0000, i[1:0]}, {14'h0000, dsel});
      chk("selected", 16'h0001, {15'h0000, sel});
      xfer(2'h1, 13'h1004, 1'b0, 16'hC3C3);
      chk("sel wr", 16'hC3C3, scr);
      xfer(2'h1, 13'h1000, 1'b0, {14'h0000, ~i[1:0]});
      chk("deselected", 16'h0000, {15'h0000, sel});
      xfer(2'h1, 13'h1004, 1'b0, 16'h1E1E);
      chk("unsel wr", 16'hC3C3, scr);
      xfer(2'h2, 13'h1004, 1'b0, 16'h0000);
      chk("unsel rd", 16'h0000, {15'h0000, rdq === 16'hC3C3});
    end
  endtask
  task t_mux;
    mux <= 1'b1;
    strap <= 2'h3;
    repeat (5) @(posedge mclk);
    chk("mux id", 16'h0001, {14'h0000, oid});
    strap <= 2'h2;
    repeat (5) @(posedge mclk);
    chk("mux id hi", 16'h0000, {14'h0000, oid});
    mux <= 1'b0;
  endtask
  task t_boot;
    load(10'h000, 16'h1357);
    load(10'h002, 16'h2468);
    strap <= 2'h0;
    xfer(2'h1, 13'h1000, 1'b0, 16'h0000);
    xfer(2'h2, 13'h0000, 1'b0, 16'h0000);
    chk("boot", 16'h1357, rdq);
    xfer(2'h2, 13'h0402, 1'b0, 16'h0000);
    chk("alias", 16'h2468, rdq);
    xfer(2'h2, 13'h1802, 1'b0, 16'h0000);
    chk("alias 6k", 16'h2468, rdq);
    xfer(2'h2, 13'h1C00, 1'b0, 16'h0000);
    chk("alias 7k", 16'h1357, rdq);
    wo <= 1'b1;
    xfer(2'h2, 13'h0003, 1'b1, 16'h0000);
    chk("word only", 16'h2468, rdq);
    wo <= 1'b0;
    w16 <= 1'b0;
    xfer(2'h2, 13'h0001, 1'b1, 16'h0000);
    chk("byte rd", 16'h0013, {8'h00, rdq[7:0]});
    w16 <= 1'b1;
    strap <= 2'h1;
    xfer(2'h1, 13'h1000, 1'b0, 16'h0001);
    xfer(2'h1, 13'h1002, 1'b0, 16'h0001);
    chk("highest_device_number", 16'h0001, {14'h0000, hdn});
    xfer(2'h2, 13'h0400, 1'b0, 16'h0000);
    chk("slot 1", 16'h1357, rdq);
    xfer(2'h2, 13'h0000, 1'b0, 16'h0000);
    chk("slot 0", 16'h0000, {15'h0000, rdq === 16'h1357});
  endtask
  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    give_verdict;
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_lanes;
    t_ident;
    t_mux;
    t_boot;
    give_verdict;
  end
endmodule
`default_nettype wire
